// ---- hw/cic_decimation_chain.sv ----
`timescale 1ns/100ps
// Oscillator phase control plus coarse and fine decimators
module cic_decimation_chain import cic_chain_pkg::*; #(
    parameter int COARSE_ACC_W = `CIC2_ACC_W,
    parameter int FINE_ACC_W = `CIC5_ACC_W
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Mode and configuration
    input wire logic i_single_real_frac,
    input wire logic i_sync_master,
    input wire logic [4:0] i_coarse_decim_ratio,
    input wire logic [2:0] i_coarse_scale,
    input wire logic [5:0] i_fine_decim_ratio,
    input wire logic [4:0] i_fine_scale,
    // Tuning word access
    input wire logic i_tuning_wr,
    input wire logic i_tuning_rd,
    input wire logic [`PHASE_W-1:0] i_tuning_wdata,
    output logic [`PHASE_W-1:0] o_oscillator_tuning_word,
    // Pins
    input wire logic i_sample_select,
    input wire logic i_oscillator_sync_pin,
    output logic o_oscillator_sync_pin,
    output logic o_oscillator_sync_pin_oe,
    // Input stream from the translator
    input wire logic i_in_valid,
    input wire iq_in_s i_in_data,
    // Oscillator state
    output logic [`PHASE_W-1:0] o_phase,
    // Output stream to the coefficient filter stage
    output logic o_out_valid,
    output pipe_word_s o_out_word
);
    // Elaboration check on accumulator width
    if (COARSE_ACC_W < `CIC_IN_W + 8) begin : g_bad_width
        $error("coarse stage accumulator too narrow");
    end

    // Pin synchronisers
    logic sel_m_r; // First stage, read only by the second
    logic sel_s_r;
    logic sync_m_r;
    logic sync_s_r;

    // Two flops per pin before any logic looks at it
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            sel_m_r <= 1'b0;
            sel_s_r <= 1'b0;
            sync_m_r <= 1'b0;
            sync_s_r <= 1'b0;
        end else begin
            sel_m_r <= i_sample_select;
            sel_s_r <= sel_m_r;
            sync_m_r <= i_oscillator_sync_pin;
            sync_s_r <= sync_m_r;
        end
    end

    // Oscillator phase and sync
    logic [`PHASE_W-1:0] phase_r; // Phase accumulator
    logic [`PHASE_W-1:0] phase_nxt;
    logic [`PHASE_W-1:0] tuning_r; // Tuning word
    logic [`PHASE_W-1:0] tuning_nxt;
    logic pending_r; // Slave write awaiting a zero crossing
    logic pending_nxt;
    logic sync_out_r; // Master pulse on the sync pin
    logic sync_out_nxt;

    // Phase advance, forced syncs and the zero-crossing resync
    always_comb begin
        logic advance;
        logic carry;
        logic [`PHASE_W-1:0] sum;
        logic access;
        advance = i_single_real_frac ? sel_s_r : i_in_valid;
        {carry, sum} = {1'b0, phase_r} + {1'b0, tuning_r};
        access = i_tuning_wr || i_tuning_rd;
        phase_nxt = phase_r;
        tuning_nxt = i_tuning_wr ? i_tuning_wdata : tuning_r;
        pending_nxt = pending_r;
        sync_out_nxt = 1'b0;
        if (i_sync_master && access) begin
            // Any access as master forces a sync
            phase_nxt = `PHASE_RESET;
            sync_out_nxt = 1'b1;
            pending_nxt = 1'b0;
        end else if (!i_sync_master && sync_s_r) begin
            // External sync resets and holds while high
            phase_nxt = `PHASE_RESET;
        end else if (i_sync_master && pending_r && advance && carry) begin
            // Phase passed zero after a slave write
            phase_nxt = `PHASE_RESET;
            sync_out_nxt = 1'b1;
            pending_nxt = 1'b0;
        end else if (advance) begin
            phase_nxt = sum;
        end
        if (!i_sync_master && i_tuning_wr) begin
            // Slave write keeps phase running
            pending_nxt = 1'b1;
        end
    end

    // Oscillator registers
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            phase_r <= `PHASE_RESET;
            tuning_r <= `TUNING_RESET;
            pending_r <= 1'b0;
            sync_out_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            tuning_r <= tuning_nxt;
            pending_r <= pending_nxt;
            sync_out_r <= sync_out_nxt;
        end
    end

    assign o_phase = phase_r;
    assign o_oscillator_tuning_word = tuning_r;
    assign o_oscillator_sync_pin = sync_out_r;
    // Pin driven only as master
    assign o_oscillator_sync_pin_oe = i_sync_master;

    // Coarse second-order decimator
    logic signed [COARSE_ACC_W-1:0] integ_r [2][`CIC2_ORDER];
    logic signed [COARSE_ACC_W-1:0] integ_nxt [2][`CIC2_ORDER];
    logic signed [COARSE_ACC_W-1:0] dly_r [2][`CIC2_ORDER];
    logic signed [COARSE_ACC_W-1:0] dly_nxt [2][`CIC2_ORDER];
    logic [4:0] cnt_r; // Decimation phase
    logic [4:0] cnt_nxt;
    logic [4:0] ratio; // Ratio with zero treated as one
    logic [2:0] scale; // Scale clamped to its top value
    logic signed [`CIC_MID_W-1:0] q_hold_r; // Q waiting for the pipe
    logic signed [`CIC_MID_W-1:0] q_hold_nxt;
    logic q_due_r; // Q goes out on the next cycle
    logic q_due_nxt;
    logic pipe_valid_r;
    logic pipe_valid_nxt;
    pipe_word_s pipe_word_r;
    pipe_word_s pipe_word_nxt;

    assign ratio = (i_coarse_decim_ratio < `COARSE_RATIO_MIN) ?
        `COARSE_RATIO_MIN : i_coarse_decim_ratio;
    assign scale = (i_coarse_scale > `COARSE_SCALE_MAX) ?
        `COARSE_SCALE_MAX : i_coarse_scale;

    // Both channels in parallel, one sample per input strobe
    always_comb begin
        logic signed [COARSE_ACC_W-1:0] acc [2];
        logic signed [COARSE_ACC_W-1:0] comb [2];
        logic signed [COARSE_ACC_W-1:0] scaled [2];
        logic dump;
        acc[0] = COARSE_ACC_W'(i_in_data.i);
        acc[1] = COARSE_ACC_W'(i_in_data.q);
        comb[0] = '0;
        comb[1] = '0;
        scaled[0] = '0;
        scaled[1] = '0;
        dump = 1'b0;
        integ_nxt = integ_r;
        dly_nxt = dly_r;
        cnt_nxt = cnt_r;
        q_hold_nxt = q_hold_r;
        q_due_nxt = 1'b0;
        pipe_valid_nxt = 1'b0;
        pipe_word_nxt = pipe_word_r;
        if (q_due_r) begin
            // Second slot of the shared pipe carries Q
            pipe_valid_nxt = 1'b1;
            pipe_word_nxt.is_q = 1'b1;
            pipe_word_nxt.data = q_hold_r;
        end
        if (i_in_valid) begin
            // Accept every strobe, no stall
            dump = (cnt_r == ratio - 5'h01);
            cnt_nxt = dump ? 5'h00 : cnt_r + 5'h01;
            for (int c = 0; c < 2; c++) begin
                for (int k = 0; k < `CIC2_ORDER; k++) begin
                    acc[c] = integ_r[c][k] + acc[c];
                    integ_nxt[c][k] = acc[c];
                end
                comb[c] = acc[c];
                if (dump) begin
                    for (int k = 0; k < `CIC2_ORDER; k++) begin
                        dly_nxt[c][k] = comb[c];
                        comb[c] = comb[c] - dly_r[c][k];
                    end
                end
                // Scale kept even when ratio is one
                scaled[c] = comb[c] >>> scale;
            end
            if (dump) begin
                // I first, Q one cycle later in the same pipe
                pipe_valid_nxt = 1'b1;
                pipe_word_nxt.is_q = 1'b0;
                pipe_word_nxt.data = scaled[0][`CIC_MID_W-1:0];
                q_hold_nxt = scaled[1][`CIC_MID_W-1:0];
                q_due_nxt = 1'b1;
            end
        end
    end

    // Coarse stage registers
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            for (int c = 0; c < 2; c++) begin
                for (int k = 0; k < `CIC2_ORDER; k++) begin
                    integ_r[c][k] <= '0;
                    dly_r[c][k] <= '0;
                end
            end
            cnt_r <= 5'h00;
            q_hold_r <= '0;
            q_due_r <= 1'b0;
            pipe_valid_r <= 1'b0;
            pipe_word_r <= '0;
        end else begin
            integ_r <= integ_nxt;
            dly_r <= dly_nxt;
            cnt_r <= cnt_nxt;
            q_hold_r <= q_hold_nxt;
            q_due_r <= q_due_nxt;
            pipe_valid_r <= pipe_valid_nxt;
            pipe_word_r <= pipe_word_nxt;
        end
    end

    // Fine fifth-order decimator
    logic [5:0] fine_ratio; // Zero treated as bypass
    logic [4:0] fine_scale; // Clamped to its top value

    assign fine_ratio = (i_fine_decim_ratio > `FINE_RATIO_MAX) ?
        `FINE_RATIO_MAX : i_fine_decim_ratio;
    assign fine_scale = (i_fine_scale > `FINE_SCALE_MAX) ?
        `FINE_SCALE_MAX : i_fine_scale;

    // Fed from the shared pipe of the coarse stage
    cic_fine_stage #(
        .ACC_W(FINE_ACC_W)
    ) u_fine (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_fine_decim_ratio(fine_ratio),
        .i_fine_scale(fine_scale),
        .i_valid(pipe_valid_r),
        .i_word(pipe_word_r),
        .o_valid(o_out_valid),
        .o_word(o_out_word)
    );
endmodule // cic_decimation_chain

// ---- hw/cic_chain_regs.svh ----
// How it works
// - In single-real-frac mode, sample-select high advances phase, else holds; otherwise each input strobe advances it.
// - Tuning-word access as master resets phase.
// - Slave tuning write leaves phase continuous.
// - Back to master: sync at zero crossing.
// - Coarse stage takes full input rate.
// - Coarse ratio 1..31 (5-bit, no clamp at 16), second-order comb response.
// - Coarse I/Q parallel, then one shared pipe.
// - Coarse scale 0..6, one bit each.
// - Coarse scale still applies when bypassed.
// - Fine ratio 1..32; one bypasses, scale ignored.
// - Fine scale 0..20 plus five, fifth order.
// - Fine stage emits one per ratio inputs.
// - Master drives sync pin, slave samples it.
`ifndef CIC_CHAIN_REGS_SVH
`define CIC_CHAIN_REGS_SVH
// Data path widths
`define CIC_IN_W 16
`define CIC_MID_W 18
`define CIC2_ACC_W 24
`define CIC5_ACC_W 43
`define PHASE_W 32
// Filter orders
`define CIC2_ORDER 2
`define CIC5_ORDER 5
// Ratio and scale ranges
`define COARSE_RATIO_MIN 5'h01
`define COARSE_RATIO_MAX 5'h10
`define FINE_RATIO_MIN 6'h01
`define FINE_RATIO_MAX 6'h20
`define COARSE_SCALE_MAX 3'h6
`define FINE_SCALE_MAX 5'h14
`define FINE_SCALE_BIAS 6'h05
// Reset values
`define PHASE_RESET 32'h0000_0000
`define TUNING_RESET 32'h0000_0000
`endif

// ---- hw/cic_chain_pkg.sv ----
package cic_chain_pkg;
`include "cic_chain_regs.svh"
    // Complex sample entering the chain
    typedef struct packed {
        logic signed [`CIC_IN_W-1:0] i;
        logic signed [`CIC_IN_W-1:0] q;
    } iq_in_s;
    // One word of the shared I/Q pipe
    typedef struct packed {
        logic is_q;
        logic signed [`CIC_MID_W-1:0] data;
    } pipe_word_s;
endpackage

// ---- hw/cic_fine_stage.sv ----
`timescale 1ns/100ps
// Fifth-order decimator on an interleaved I/Q stream
module cic_fine_stage import cic_chain_pkg::*; #(
    parameter int ACC_W = `CIC5_ACC_W
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Configuration
    input wire logic [5:0] i_fine_decim_ratio,
    input wire logic [4:0] i_fine_scale,
    // Input stream
    input wire logic i_valid,
    input wire pipe_word_s i_word,
    // Output stream
    output logic o_valid,
    output pipe_word_s o_word
);
    localparam int ORD = `CIC5_ORDER;

    // Elaboration check on accumulator width
    if (ACC_W < `CIC_MID_W + 25) begin : g_bad_width
        $error("fine stage accumulator too narrow");
    end

    logic signed [ACC_W-1:0] integ_r [2][ORD]; // Integrators per channel
    logic signed [ACC_W-1:0] integ_nxt [2][ORD];
    logic signed [ACC_W-1:0] dly_r [2][ORD]; // Comb delays per channel
    logic signed [ACC_W-1:0] dly_nxt [2][ORD];
    logic [5:0] cnt_r; // Decimation phase, counted on I words
    logic [5:0] cnt_nxt;
    logic dump_r; // Dump decision shared by the Q word
    logic dump_nxt;
    logic valid_nxt;
    pipe_word_s word_r;
    pipe_word_s word_nxt;

    // Integrate, decimate, comb and scale
    always_comb begin
        logic signed [ACC_W-1:0] acc;
        logic signed [ACC_W-1:0] comb;
        logic signed [ACC_W-1:0] scaled;
        logic ch;
        logic dump;
        acc = '0;
        comb = '0;
        scaled = '0;
        ch = i_word.is_q;
        dump = 1'b0;
        integ_nxt = integ_r;
        dly_nxt = dly_r;
        cnt_nxt = cnt_r;
        dump_nxt = dump_r;
        valid_nxt = 1'b0;
        word_nxt = word_r;
        if (i_valid && i_fine_decim_ratio <= `FINE_RATIO_MIN) begin
            // Bypass: stage and its scale are skipped
            valid_nxt = 1'b1;
            word_nxt = i_word;
        end else if (i_valid) begin
            // Wrap-around sums cancel overflow in the combs
            acc = ACC_W'(i_word.data);
            for (int k = 0; k < ORD; k++) begin
                acc = integ_r[ch][k] + acc;
                integ_nxt[ch][k] = acc;
            end
            if (!ch) begin
                // Q word reuses the decision taken on I
                dump = (cnt_r == i_fine_decim_ratio - 6'h01);
                dump_nxt = dump;
                cnt_nxt = dump ? 6'h00 : cnt_r + 6'h01;
            end else begin
                dump = dump_r;
            end
            if (dump) begin
                comb = acc;
                for (int k = 0; k < ORD; k++) begin
                    dly_nxt[ch][k] = comb;
                    comb = comb - dly_r[ch][k];
                end
                // Fixed five-bit bias plus programmed scale
                scaled = comb >>> (6'(i_fine_scale) + `FINE_SCALE_BIAS);
                valid_nxt = 1'b1;
                word_nxt.is_q = ch;
                word_nxt.data = scaled[`CIC_MID_W-1:0];
            end
        end
    end

    // State registers
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            for (int c = 0; c < 2; c++) begin
                for (int k = 0; k < ORD; k++) begin
                    integ_r[c][k] <= '0;
                    dly_r[c][k] <= '0;
                end
            end
            cnt_r <= 6'h00;
            dump_r <= 1'b0;
            o_valid <= 1'b0;
            word_r <= '0;
        end else begin
            integ_r <= integ_nxt;
            dly_r <= dly_nxt;
            cnt_r <= cnt_nxt;
            dump_r <= dump_nxt;
            o_valid <= valid_nxt;
            word_r <= word_nxt;
        end
    end

    assign o_word = word_r;
endmodule // cic_fine_stage

// ---- test/cic_decimation_chain_chk.sv ----
`timescale 1ns/100ps
// Port watcher for oscillator resync and the shared I/Q pipe
module cic_decimation_chain_chk import cic_chain_pkg::*; (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Configuration and strobes
    input wire logic i_single_real_frac,
    input wire logic i_sync_master,
    input wire logic [4:0] i_coarse_decim_ratio,
    input wire logic [2:0] i_coarse_scale,
    input wire logic [5:0] i_fine_decim_ratio,
    input wire logic [4:0] i_fine_scale,
    input wire logic i_tuning_wr,
    input wire logic i_tuning_rd,
    input wire logic [31:0] i_tuning_wdata,
    input wire logic i_sample_select,
    input wire logic i_oscillator_sync_pin,
    input wire logic i_in_valid,
    input wire iq_in_s i_in_data,
    // Design outputs
    input wire logic [31:0] o_oscillator_tuning_word,
    input wire logic o_oscillator_sync_pin,
    input wire logic o_oscillator_sync_pin_oe,
    input wire logic [31:0] o_phase,
    input wire logic o_out_valid,
    input wire pipe_word_s o_out_word
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    oe_dir_a: assert property (o_oscillator_sync_pin_oe == i_sync_master)
        else $error("sync pin enable does not follow master select");
    access_sync_a: assert property (i_sync_master && (i_tuning_wr || i_tuning_rd)
        |=> o_phase == '0 && o_oscillator_sync_pin) else $error("no resync");
    tuning_load_a: assert property (i_tuning_wr
        |=> o_oscillator_tuning_word == $past(i_tuning_wdata)) else $error("tw");
    slave_hold_a: assert property (!i_sync_master && i_tuning_wr && !i_in_valid
        && !i_single_real_frac && !i_oscillator_sync_pin
        |=> o_phase == $past(o_phase)) else $error("slave write moved phase");
    advance_a: assert property (!i_single_real_frac && i_sync_master
        && i_in_valid && !i_tuning_wr && !i_tuning_rd |=> o_phase == $past(o_phase)
        + $past(o_oscillator_tuning_word) || o_phase == '0 && o_oscillator_sync_pin)
        else $error("bad phase step");
    sync_zero_a: assert property ($rose(o_oscillator_sync_pin)
        |-> o_phase == '0 || $past(o_phase) == '0) else $error("sync off zero");
    pulse_one_a: assert property (o_oscillator_sync_pin && !i_tuning_wr
        && !i_tuning_rd && !i_in_valid && !i_single_real_frac
        |=> !o_oscillator_sync_pin) else $error("sync pulse too long");
    i_then_q_a: assert property (o_out_valid && !o_out_word.is_q
        |=> o_out_valid && o_out_word.is_q) else $error("Q word missing");
    q_after_i_a: assert property (o_out_valid && o_out_word.is_q
        |-> $past(o_out_valid) && !$past(o_out_word.is_q)) else $error("lone Q");
    bypass_data_a: assert property (i_in_valid && i_coarse_decim_ratio == 5'h01
        && i_fine_decim_ratio == 6'h01 |-> ##2 o_out_valid && o_out_word.data ==
        18'($past(i_in_data.i, 2)) >>> $past(i_coarse_scale, 2))
        else $error("bypass word wrong");
    // Main scenarios reached
    cover property (o_oscillator_sync_pin && i_sync_master);
    cover property (o_out_valid && o_out_word.is_q);
    cover property (i_tuning_rd && i_sync_master);
endmodule // cic_decimation_chain_chk

bind cic_decimation_chain cic_decimation_chain_chk u_chk (.*);

// ---- test/cic_src_model.sv ----
`timescale 1ns/100ps
// Upstream source: strobed I/Q samples plus the sample-select pin
module cic_src_model import cic_chain_pkg::*; (
    // Clock
    input wire logic i_mclk,
    // Commands from the bench
    input wire logic i_go,
    input wire logic [7:0] i_n,
    input wire logic [1:0] i_sel_len,
    input wire iq_in_s i_sample,
    // Toward the chain
    output logic o_busy,
    output logic o_valid,
    output iq_in_s o_data,
    output logic o_sel
);
    // One sample per three clocks, so the Q slot is always free
    initial begin
        o_busy = 1'b0;
        o_valid = 1'b0;
        o_data = '0;
        o_sel = 1'b0;
        forever begin
            @(negedge i_mclk);
            if (i_go === 1'b1) begin
                o_busy = 1'b1;
                repeat (i_n) begin
                    o_valid = 1'b1;
                    o_data = i_sample;
                    o_sel = 1'b1;
                    @(negedge i_mclk);
                    o_valid = 1'b0;
                    // Stale data never lingers on the bus
                    o_data = ~i_sample;
                    // Select drops after one clock unless told to hold
                    if (i_sel_len < 2'h2) o_sel = 1'b0;
                    @(negedge i_mclk);
                    o_sel = 1'b0;
                    @(negedge i_mclk);
                end
                o_busy = 1'b0;
            end
        end
    end
endmodule // cic_src_model

// ---- test/cic_decimation_chain_tb_top.sv ----
`timescale 1ns/100ps
// Self-checking bench for the decimation chain
module cic_decimation_chain_tb_top import cic_chain_pkg::*;;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
    // Stimulus, all moved at the falling edge
    logic i_mclk = 1'b0, i_reset = 1'b1, frac = 1'b0, master = 1'b1;
    logic [4:0] c_ratio = 5'h01, f_scale = 5'h00;
    logic [2:0] c_scale = 3'h0;
    logic [5:0] f_ratio = 6'h01;
    logic wr = 1'b0, rd = 1'b0, pin_in = 1'b0, go = 1'b0, sync_seen = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [7:0] n = 8'h01;
    logic [1:0] sel_len = 2'h1;
    iq_in_s smp = '0, in_data;
    // Observed
    logic in_valid, sel, busy, sync_o, sync_oe, out_valid;
    logic [31:0] tword, phase;
    pipe_word_s out_word;
    pipe_word_s outs[$];
    int mismatches = 0, n_tests = 0, cyc = 0;
    cic_decimation_chain uut (.i_mclk(i_mclk), .i_reset(i_reset),
        .i_single_real_frac(frac), .i_sync_master(master),
        .i_coarse_decim_ratio(c_ratio), .i_coarse_scale(c_scale),
        .i_fine_decim_ratio(f_ratio), .i_fine_scale(f_scale),
        .i_tuning_wr(wr), .i_tuning_rd(rd), .i_tuning_wdata(wdata),
        .o_oscillator_tuning_word(tword), .i_sample_select(sel),
        .i_oscillator_sync_pin(pin_in), .o_oscillator_sync_pin(sync_o),
        .o_oscillator_sync_pin_oe(sync_oe), .i_in_valid(in_valid),
        .i_in_data(in_data), .o_phase(phase), .o_out_valid(out_valid),
        .o_out_word(out_word));
    cic_src_model u_src (.i_mclk(i_mclk), .i_go(go), .i_n(n),
        .i_sel_len(sel_len), .i_sample(smp), .o_busy(busy),
        .o_valid(in_valid), .o_data(in_data), .o_sel(sel));
    initial forever #20 i_mclk = ~i_mclk;
    // Hang guard, far above the few hundred cycles needed
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            wrap_up();
        end
    end
    // Collect pipe words and sync pulses mid-cycle
    always @(negedge i_mclk) begin
        if (out_valid === 1'b1) outs.push_back(out_word);
        if (sync_o === 1'b1) sync_seen = 1'b1;
    end
    task step(input int k);
        repeat (k) @(negedge i_mclk);
    endtask
    task do_reset;
        i_reset <= 1'b1;
        step(4);
        i_reset <= 1'b0;
        step(1);
        outs.delete();
    endtask
    task run(input logic [7:0] k, input logic [1:0] sl, input iq_in_s v);
        n <= k;
        sel_len <= sl;
        smp <= v;
        go <= 1'b1;
        step(1);
        go <= 1'b0;
        step(1);
        while (busy) step(1);
        step(4);
    endtask
    // One write or read; result seen one edge later
    task access(input logic w, input logic [31:0] d);
        if (w) wr <= 1'b1;
        else rd <= 1'b1;
        wdata <= d;
        step(1);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task t_master;
        `CHK("sync_oe", 1'b1, sync_oe)
        access(1'b1, 32'h1000_0000);
        `CHK("tuning", 32'h1000_0000, tword)
        `CHK("phase_wr", 32'h0000_0000, phase)
        `CHK("sync_on", 1'b1, sync_o)
        step(1);
        `CHK("sync_off", 1'b0, sync_o)
        run(8'h03, 2'h1, smp);
        `CHK("phase_adv", 32'h3000_0000, phase)
        access(1'b0, 32'h0000_0000);
        `CHK("phase_rd", 32'h0000_0000, phase)
        step(1);
    endtask
    // Held select advances once per clock while high
    task t_frac;
        frac <= 1'b1;
        step(1);
        run(8'h02, 2'h2, smp);
        `CHK("sel_hold", 32'h4000_0000, phase)
        run(8'h02, 2'h1, smp);
        `CHK("sel_once", 32'h6000_0000, phase)
        frac <= 1'b0;
        step(1);
    endtask
    task t_slave;
        access(1'b1, 32'h4000_0000);
        step(1);
        run(8'h01, 2'h1, smp);
        master <= 1'b0;
        step(1);
        `CHK("sync_oe_slave", 1'b0, sync_oe)
        sync_seen = 1'b0;
        access(1'b1, 32'h8000_0000);
        `CHK("slave_keep", 32'h4000_0000, phase)
        step(1);
        run(8'h01, 2'h1, smp);
        `CHK("slave_adv", 32'hC000_0000, phase)
        `CHK("slave_nosync", 1'b0, sync_seen)
        // External pulse as slave clears phase and holds it
        pin_in <= 1'b1;
        step(4);
        `CHK("ext_sync", 32'h0000_0000, phase)
        run(8'h01, 2'h1, smp);
        `CHK("ext_hold", 32'h0000_0000, phase)
        pin_in <= 1'b0;
        step(4);
        master <= 1'b1;
        step(1);
        // First step lands on half a turn, second one wraps
        run(8'h02, 2'h1, smp);
        `CHK("wrap_phase", 32'h0000_0000, phase)
        `CHK("wrap_sync", 1'b1, sync_seen)
    endtask
    // Bypassed chain, every coarse scale, fine scale ignored
    task t_scales;
        logic signed [17:0] e;
        do_reset();
        f_scale <= 5'h14;
        smp <= '{i: 16'h03E8, q: 16'hFC18};
        for (int s = 0; s <= 6; s++) begin
            c_scale <= 3'(s);
            step(1);
            outs.delete();
            run(8'h01, 2'h1, smp);
            `CHK("pair_cnt", 2, outs.size())
            e = 18'(smp.i) >>> s;
            `CHK("i_scaled", e, outs[0].data)
            e = 18'(smp.q) >>> s;
            `CHK("q_scaled", e, outs[1].data)
            `CHK("q_flag", 1'b1, outs[1].is_q)
        end
    endtask
    // Ratio 16, scale 6: steady gain 256/64
    task t_coarse;
        do_reset();
        c_ratio <= 5'h10;
        c_scale <= 3'h6;
        f_scale <= 5'h00;
        step(1);
        run(8'h30, 2'h1, '{i: 16'h0064, q: 16'hFF9C});
        `CHK("coarse_cnt", 6, outs.size())
        `CHK("coarse_i", 18'h00190, outs[4].data)
        `CHK("coarse_q", 18'h3FE70, outs[5].data)
    endtask
    // Fine ratio 4, scale 1: steady gain 1024/64
    task t_fine;
        do_reset();
        c_ratio <= 5'h01;
        c_scale <= 3'h0;
        f_ratio <= 6'h04;
        f_scale <= 5'h01;
        step(1);
        run(8'h20, 2'h1, '{i: 16'h0032, q: 16'hFFCE});
        `CHK("fine_cnt", 16, outs.size())
        `CHK("fine_i", 18'h00320, outs[14].data)
        `CHK("fine_q", 18'h3FCE0, outs[15].data)
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        do_reset();
        t_master();
        t_frac();
        t_slave();
        t_scales();
        t_coarse();
        t_fine();
        wrap_up();
    end
endmodule // cic_decimation_chain_tb_top
